/* design/mcp_pkg.sv */
// Purpose: Shared types and constants for the memory channel host controller.
// Assumes: 100 MHz clock, 10 ns period.
// Notes:   Times are kept in ns; cycle counts are derived from them.
package mcp_pkg;

  localparam int CLK_NS    = 10;             // Clock period in ns
  localparam int ADDR_W    = 24;             // Word address width
  localparam int DATA_W    = 16;             // Data width without parity
  localparam int LINE_W    = 18;             // Data plus two parity lines
  localparam int FIFO_DEPTH = 32;            // Command buffer depth

  localparam int T_WS_NS   = 70;             // Write command before write data
  localparam int T_RP_NS   = 50;             // Least request pulse width
  // Least times round up to whole cycles
  localparam int WS_CYC    = (T_WS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC    = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W     = 4;              // Width of the phase counter

  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000; // Address after reset
  localparam logic [LINE_W-1:0] LINE_RST = 18'h00000;  // Data lines after reset

  // One command from the user
  typedef struct packed {
    logic              lock;   // Hold the channel for this and the next access
    logic              write;  // High writes memory, low reads it
    logic [ADDR_W-1:0] addr;   // Word address
    logic [DATA_W-1:0] data;   // Write data
  } mcp_cmd_s;

  // One read answer to the user
  typedef struct packed {
    logic              par_err; // Odd parity failed on either byte
    logic [DATA_W-1:0] data;    // Read data
  } mcp_rsp_s;

  // Odd parity bit for one byte
  function automatic logic mcp_odd_par(input logic [7:0] b);
    mcp_odd_par = ~(^b);
  endfunction : mcp_odd_par

  // Both parity lines for a word, upper byte in the high bit
  function automatic logic [1:0] mcp_word_par(input logic [DATA_W-1:0] w);
    mcp_word_par = {mcp_odd_par(w[15:8]), mcp_odd_par(w[7:0])};
  endfunction : mcp_word_par

endpackage : mcp_pkg

/* design/mcp_fifo.sv */
// Purpose: Command buffer between the user and the channel sequencer.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Full and empty are registered so the ready and valid outputs are clean.
module mcp_fifo import mcp_pkg::*; #(
  parameter int WIDTH = 42,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];          // Storage
  logic [AW-1:0]    wr_ptr, next_wr_ptr;  // Write pointer
  logic [AW-1:0]    rd_ptr, next_rd_ptr;  // Read pointer
  logic [AW:0]      count, next_count;    // Words held
  logic             full, next_full;      // Registered full flag
  logic             empty, next_empty;    // Registered empty flag
  logic             push, pop;

  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr];

  // Pointer and flag updates
  always_comb begin
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = (AW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (AW+1)'(count - 1'b1);
    end
    next_full  = (next_count == (AW+1)'(DEPTH));
    next_empty = (next_count == '0);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      full   <= 1'b0;
      empty  <= 1'b1;
      in_ready <= 1'b1;        // Empty buffer takes words at once
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      full   <= next_full;
      empty  <= next_empty;
      in_ready <= !next_full;  // Own flop so the user sees no gate after it
    end
  end

  // Storage is not reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : mcp_fifo

/* design/mcp_host.sv */
// Purpose: Host end of a memory channel; turns buffered commands into accesses.
// Assumes: Port strobes and read data arrive asynchronously and are synchronised.
// Notes:   One access in flight at a time; read answers cannot be stalled.
// How it works
// - Drive the 24-bit word address every access
// - Direction high writes, low reads
// - Inhibit asserted during power-down blocks requests
// - Source drives data on writes, port on reads
// - Odd parity per byte travels with data
// - Lock held gives two uninterrupted accesses
// - Raise direction soon after each read completes
// - No new request before acceptance pulse ends
module mcp_host import mcp_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // User command stream
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire mcp_cmd_s          cmd,
  // User read answers
  output logic                   rsp_valid,
  output mcp_rsp_s               rsp,
  // User power control
  input  wire logic              power_down,
  // Channel address cable
  output logic      [ADDR_W-1:0] addr,
  output logic                   req,
  output logic                   write,
  output logic                   memory_inhibit,
  output logic                   lock,
  // Channel data cable, parity in bits 17:16
  input  wire logic [LINE_W-1:0] data_lines_in,
  output logic      [LINE_W-1:0] data_lines_out,
  output logic                   data_lines_oe,
  input  wire logic              acceptance_strobe,
  input  wire logic              transfer_done
);

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,   // Waiting for a command
    ST_SETUP  = 5'b00010,   // Address and direction settle
    ST_REQ    = 5'b00100,   // Request high until accepted
    ST_WAIT   = 5'b01000,   // Waiting for transfer done
    ST_FINISH = 5'b10000    // Release the data lines
  } mcp_state_e;

  // Sequencer state
  mcp_state_e         state, next_state;
  mcp_cmd_s           cur, next_cur;          // Command in flight
  logic [CNT_W-1:0]   cnt, next_cnt;          // Phase counter
  logic               acc_got, next_acc_got;  // Acceptance seen this access
  logic               done_got, next_done_got;// Transfer done seen
  // Registered outputs and their next values
  logic [ADDR_W-1:0]  next_addr;
  logic               next_req, next_write, next_inhibit, next_lock;
  logic [LINE_W-1:0]  next_dout;
  logic               next_oe, next_rsp_valid;
  mcp_rsp_s           next_rsp;
  // Synchronisers for pins from the port
  logic [LINE_W-1:0]  din_m, din_s;
  logic               acc_m, acc_s, acc_d;
  logic               done_m, done_s, done_d;
  logic               acc_rise, done_rise;
  // Buffer drain side
  logic               fq_valid, fq_pop;
  mcp_cmd_s           fq_cmd;

  // Commands queue here so the user can run ahead of the channel
  mcp_fifo #(
    .WIDTH ($bits(mcp_cmd_s)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   (cmd),
    .out_valid (fq_valid),
    .out_ready (fq_pop),
    .out_data  (fq_cmd)
  );

  // Two flops on every pin input; strobes add a third so their rising edge can be found
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      din_m  <= LINE_RST;
      din_s  <= LINE_RST;
      acc_m  <= 1'b0;
      acc_s  <= 1'b0;
      acc_d  <= 1'b0;
      done_m <= 1'b0;
      done_s <= 1'b0;
      done_d <= 1'b0;
    end else begin
      din_m  <= data_lines_in;
      din_s  <= din_m;
      acc_m  <= acceptance_strobe;
      acc_s  <= acc_m;
      acc_d  <= acc_s;
      done_m <= transfer_done;
      done_s <= done_m;
      done_d <= done_s;
    end
  end

  assign acc_rise  = acc_s && !acc_d;   // Acceptance pulse begins
  assign done_rise = done_s && !done_d; // Transfer done pulse begins

  // Start only when idle, powered and the last acceptance pulse is over;
  // after a read, direction stays high a second cycle so port drivers let go
  assign fq_pop = (state == ST_IDLE) && fq_valid && !memory_inhibit && !acc_s
                  && !rsp_valid;

  // Sequencer next values
  always_comb begin
    next_state     = state;
    next_cur       = cur;
    next_cnt       = cnt;
    next_acc_got   = acc_got;
    next_done_got  = done_got;
    next_addr      = addr;
    next_req       = req;
    next_write     = write;
    next_lock      = lock;
    next_dout      = data_lines_out;
    next_oe        = data_lines_oe;
    next_rsp_valid = 1'b0;
    next_rsp       = rsp;
    next_inhibit   = power_down;
    // Done can arrive while request is still high in a slow bank
    if ((state == ST_REQ || state == ST_WAIT) && done_rise) begin
      next_done_got = 1'b1;
      // Read data is valid when the done pulse starts
      next_rsp.data    = din_s[DATA_W-1:0];
      next_rsp.par_err = (din_s[LINE_W-1:DATA_W] != mcp_word_par(din_s[DATA_W-1:0]));
    end
    unique case (state)
      ST_IDLE: begin
        if (fq_pop) begin
          next_cur      = fq_cmd;
          next_addr     = fq_cmd.addr;
          next_write    = fq_cmd.write;
          next_dout     = {mcp_word_par(fq_cmd.data), fq_cmd.data};
          next_lock     = lock || fq_cmd.lock;
          next_cnt      = '0;
          next_acc_got  = 1'b0;
          next_done_got = 1'b0;
          next_state    = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Data is enabled only after the write command has settled
        next_cnt = CNT_W'(cnt + 1'b1);
        if (cnt == CNT_W'(WS_CYC - 1)) begin
          next_oe    = cur.write;
          next_req   = 1'b1;
          next_cnt   = '0;
          next_state = ST_REQ;
        end
      end
      ST_REQ: begin
        // Request stays until accepted and at least its least width
        if (cnt != CNT_W'(RP_CYC)) begin
          next_cnt = CNT_W'(cnt + 1'b1);
        end
        if (acc_rise) begin
          next_acc_got = 1'b1;
        end
        if ((acc_got || acc_rise) && cnt >= CNT_W'(RP_CYC - 1)) begin
          next_req   = 1'b0;
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Both the acceptance pulse end and the done pulse are needed
        if ((done_got || done_rise) && !acc_s) begin
          next_state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        next_oe        = 1'b0;
        next_write     = 1'b1;
        next_rsp_valid = !cur.write;
        if (!cur.lock) begin
          next_lock = 1'b0;
        end
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state          <= ST_IDLE;
      cur            <= '0;
      cnt            <= '0;
      acc_got        <= 1'b0;
      done_got       <= 1'b0;
      addr           <= ADDR_RST;
      req            <= 1'b0;
      write          <= 1'b1;
      memory_inhibit <= 1'b1;
      lock           <= 1'b0;
      data_lines_out <= LINE_RST;
      data_lines_oe  <= 1'b0;
      rsp_valid      <= 1'b0;
      rsp            <= '0;
    end else begin
      state          <= next_state;
      cur            <= next_cur;
      cnt            <= next_cnt;
      acc_got        <= next_acc_got;
      done_got       <= next_done_got;
      addr           <= next_addr;
      req            <= next_req;
      write          <= next_write;
      memory_inhibit <= next_inhibit;
      lock           <= next_lock;
      data_lines_out <= next_dout;
      data_lines_oe  <= next_oe;
      rsp_valid      <= next_rsp_valid;
      rsp            <= next_rsp;
    end
  end

  // Accesses finished while the lock is high
  logic [2:0] lk_cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lk_cnt <= '0;
    end else if (!lock) begin
      lk_cnt <= '0;
    end else if (state == ST_FINISH && lk_cnt != 3'h7) begin
      lk_cnt <= 3'(lk_cnt + 1'b1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_read_end;
    (state == ST_FINISH) && !cur.write;
  endsequence

  a_req_held:     assert property (req && !acc_got && !acc_rise |=> req)
    else $error("request dropped before acceptance");
  a_addr_stable:  assert property (req && $past(req) |-> $stable(addr) && $stable(write))
    else $error("address or direction moved under request");
  a_issue_clear:  assert property ($rose(req) |-> !acc_s)
    else $error("request raised during acceptance pulse");
  a_inhibit_req:  assert property ($rose(req) |-> !$past(memory_inhibit, 7))
    else $error("request started while inhibited");
  a_read_nodrive: assert property (req && !write |-> !data_lines_oe)
    else $error("host drives data on a read");
  a_write_drive:  assert property (req && write |-> data_lines_oe)
    else $error("host not driving write data");
  a_parity_out:   assert property (data_lines_oe |->
      data_lines_out[17:16] == mcp_word_par(data_lines_out[15:0]))
    else $error("bad outgoing parity");
  a_dir_after:    assert property (s_read_end |=> write && !data_lines_oe ##1 write)
    else $error("direction not raised after read");
  a_lock_pair:    assert property ($fell(lock) |-> lk_cnt >= 3'h2)
    else $error("lock released before two accesses");
  a_dir_match:    assert property ($rose(req) |-> write == cur.write)
    else $error("direction does not match command");

endmodule : mcp_host

/* testbench/mcp_port_model.sv */
// Purpose: Behavioural memory port on the far side of the host channel.
// Assumes: One access at a time; strobes move 1 ns after a clock edge.
// Notes:   Released data lines show the inverse of their last value.
module mcp_port_model (
  // Clock and address cable
  input  wire logic        clk,
  input  wire logic [23:0] addr,
  input  wire logic        req,
  input  wire logic        write,
  input  wire logic        memory_inhibit,
  input  wire logic        lock,
  // Data cable and strobes
  input  wire logic [17:0] line_in,
  output logic      [17:0] line_out,
  output logic             line_oe,
  output logic             acceptance_strobe,
  output logic             transfer_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int          wait_cyc = 0;       // Busy bank cycles before acceptance
  bit          bad_par  = 0;       // Corrupt upper parity on reads
  int          n_err    = 0;       // Channel faults made by the host
  int          n_acc    = 0;       // Accesses served
  int          n_lock   = 0;       // Accesses seen with lock high
  logic [17:0] mem [logic [23:0]]; // Stored words with parity
  logic [23:0] a;                  // Address of the access in hand
  logic        w;                  // Direction of the access in hand
  logic        req_d    = 0;       // Request one edge ago
  // Odd parity of each byte, upper byte in the high bit
  function automatic logic [1:0] odd2(input logic [15:0] d);
    return {~^d[15:8], ~^d[7:0]};
  endfunction : odd2
  initial begin
    line_out = 18'h00000;
    line_oe = 0;
    acceptance_strobe = 0;
    transfer_done = 0;
  end
  // New request while the acceptance pulse stands is a fault
  always @(posedge clk) begin
    if (req === 1'b1 && req_d === 1'b0 && acceptance_strobe) n_err++;
    req_d <= req;
  end
  // One access per request
  always begin
    @(posedge clk iff req === 1'b1);
    a = addr;
    w = write;
    n_acc++;
    if (lock === 1'b1) n_lock++;
    if (memory_inhibit !== 1'b0) n_err++;
    repeat (20 + wait_cyc) @(posedge clk);
    if (addr !== a || write !== w) n_err++;
    #1 acceptance_strobe = 1;
    // Reads put data out before the done strobe
    if (!w) begin
      line_out = mem.exists(a) ? mem[a] : {odd2(16'h0000), 16'h0000};
      line_out[17] ^= bad_par;
      line_oe = 1;
    end
    repeat (6) @(posedge clk);
    #1 acceptance_strobe = 0;
    repeat (2) @(posedge clk);
    // Writes are taken off the wire here
    if (w) begin
      if (line_in[17:16] !== odd2(line_in[15:0])) n_err++;
      mem[a] = line_in;
      line_out = ~line_in;
    end
    #1 transfer_done = 1;
    repeat (7) @(posedge clk);
    #1 transfer_done = 0;
    // Drivers stay on until direction goes high again
    if (!w) begin
      repeat (60) if (write !== 1'b1) @(posedge clk);
      if (write !== 1'b1) n_err++;
      line_oe = 0;
      line_out = ~line_out;
    end
  end
endmodule : mcp_port_model

/* testbench/tb_memory_channel_port.sv */
// Purpose: Self-checking bench for the memory channel host.
// Assumes: Inputs move 1 ns after each rising clock edge.
// Notes:   Read answers are queued as they appear; they cannot be stalled.
module tb_memory_channel_port import mcp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 0, resetn = 0, cmd_valid = 0, power_down = 0;
  mcp_cmd_s          cmd = '0;
  mcp_rsp_s          rsp;
  logic              cmd_ready, rsp_valid, req, write, memory_inhibit, lock;
  logic              h_oe, m_oe, acc, done;
  logic [ADDR_W-1:0] addr;
  logic [LINE_W-1:0] h_out, m_out, line;
  int                n_mismatch = 0, n_compared = 0, n_cyc = 0;
  mcp_rsp_s          rsp_q[$]; // Read answers not yet judged
  // Host wins the wire while it drives; otherwise the port's lines
  assign line = h_oe ? h_out : m_out;
  always #5 clk = ~clk;
  mcp_host i_dut (
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .power_down(power_down),
    .addr(addr), .req(req), .write(write), .memory_inhibit(memory_inhibit),
    .lock(lock), .data_lines_in(line), .data_lines_out(h_out),
    .data_lines_oe(h_oe), .acceptance_strobe(acc), .transfer_done(done));
  mcp_port_model i_port (
    .clk(clk), .addr(addr), .req(req), .write(write),
    .memory_inhibit(memory_inhibit), .lock(lock), .line_in(line),
    .line_out(m_out), .line_oe(m_oe), .acceptance_strobe(acc), .transfer_done(done));
  // Collect each one-cycle answer at its edge
  always @(posedge clk) if (rsp_valid === 1'b1) rsp_q.push_back(rsp);
  // Port must be off the data lines whenever the host drives them
  always @(posedge clk) if (h_oe === 1'b1) check(m_oe, 1'b0);
  // Hang guard
  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  // Offer one command and hold it until taken
  task automatic push(input logic lk, input logic wr, input logic [23:0] a,
                      input logic [15:0] d);
    @(posedge clk) #1;
    cmd_valid = 1;
    cmd = '{lock: lk, write: wr, addr: a, data: d};
    while (cmd_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
    cmd_valid = 0;
  endtask : push
  // Next read answer, unknown if none comes in time
  task automatic get_rsp(output mcp_rsp_s r);
    for (int k = 0; k < 4000 && rsp_q.size() == 0; k++) @(posedge clk);
    r = rsp_q.size() ? rsp_q.pop_front() : 'x;
    @(posedge clk) #1;
  endtask : get_rsp
  // Outputs while reset is held
  task automatic t_reset();
    #1;
    check({cmd_ready, rsp_valid, req, write, memory_inhibit, lock, h_oe}, 7'h4C);
    check(addr, 24'h000000);
  endtask : t_reset
  // Write then read back at the top of the address range and at address 1
  task automatic t_write_read();
    mcp_rsp_s          r;
    logic [23:0]       a[2] = '{24'hFFFFFF, 24'h000001};
    logic [15:0]       d[2] = '{16'hA55A, 16'h0100};
    for (int i = 0; i < 2; i++) begin
      push(0, 1, a[i], d[i]);
      push(0, 0, a[i], 16'h0000);
      get_rsp(r);
      check(r, {1'b0, d[i]});
      check(i_port.mem[a[i]], {~^d[i][15:8], ~^d[i][7:0], d[i]});
      check(write, 1'b1);
    end
  endtask : t_write_read
  // Bad upper parity on a read is flagged
  task automatic t_parity();
    mcp_rsp_s r;
    i_port.bad_par = 1;
    push(0, 0, 24'h000001, 16'h0000);
    get_rsp(r);
    check(r, {1'b1, 16'h0100});
    i_port.bad_par = 0;
  endtask : t_parity
  // Locked write then read hold the lock pin over both
  task automatic t_lock();
    mcp_rsp_s r;
    int       n0 = i_port.n_lock;
    push(1, 1, 24'h123456, 16'h00FF);
    push(0, 0, 24'h123456, 16'h0000);
    get_rsp(r);
    check(r, {1'b0, 16'h00FF});
    check(i_port.n_lock - n0, 2);
    check(lock, 1'b0);
  endtask : t_lock
  // Fill the buffer while inhibited, then drain against a busy bank
  task automatic t_fill();
    mcp_rsp_s r;
    int       n0;
    @(posedge clk) #1;
    power_down = 1;
    repeat (2) @(posedge clk);
    check(memory_inhibit, 1'b1);
    for (int i = 0; i < 32; i++) push(0, 1, 24'h000100 + i, 16'h1000 + i);
    check(cmd_ready, 1'b0);
    check(req, 1'b0);
    n0 = i_port.n_acc;
    i_port.wait_cyc = 25;
    power_down = 0;
    push(0, 0, 24'h00011F, 16'h0000);
    get_rsp(r);
    check(r, {1'b0, 16'h101F});
    check(i_port.n_acc - n0, 33);
    i_port.wait_cyc = 0;
  endtask : t_fill
  initial begin
    // Reset flops only settle at the first edge with reset low
    repeat (2) @(posedge clk);
    t_reset();
    repeat (10) @(posedge clk);
    #1 resetn = 1;
    t_write_read();
    t_parity();
    t_lock();
    t_fill();
    check(i_port.n_err, 0);
    report_and_stop();
  end
endmodule : tb_memory_channel_port
